// ===== hw/epu_cmd_decoder.v
// power, update, colour mode, waveform and thermal command decoder
`timescale 1ns/10ps
`default_nettype none
`include "epu_consts.vh"

module epu_cmd_decoder #(
    parameter [22:0] WARMUP_CYCLES = `EPU_WARMUP_MS * `EPU_CLK_KHZ,
    parameter [22:0] THERMAL_CYCLES = `EPU_THERMAL_US * `EPU_CLK_KHZ / 1000,
    parameter [22:0] UPDATE_CYCLES = `EPU_UPDATE_CYCLES
) (
    input wire mclk,                        // 25 MHz system clock
    input wire rst_b,                       // async reset, active low
    input wire cmd_strobe,                  // one-cycle pulse: command byte valid
    input wire [7:0] cmd_code,              // command byte
    input wire param_strobe,                // one-cycle pulse: parameter byte valid
    input wire [7:0] param_byte,            // parameter byte
    input wire cap_booster_select,          // 1: capacitor booster supplies
    input wire nvm_bypass,                  // 1: host waveform table in use
    input wire auto_thermal_pick,           // automatic temperature pick on
    input wire secondary_select_pin,        // pin: high means slave chip
    input wire update_trigger_pin,          // pin: update trigger from master
    input wire chain_clock_pin,             // pin: chain clock from master
    input wire [6:0] thermal_adc_value,     // temperature detector output
    input wire [41:0] thermal_bounds,       // temperature boundaries, ascending
    output reg first_boost_rail_en,         // first boost rail on
    output reg panel_drive_rail_en,         // panel drive rail on
    output reg second_boost_rail_en,        // second boost rail on
    output reg high_voltage_regulator_en,   // high-voltage regulator on
    output reg osc_en,                      // internal oscillator run
    output reg update_busy,                 // display update in progress
    output reg backplane_drive_black,       // backplane drive, 1 black
    output reg thermal_busy,                // temperature conversion running
    output reg [6:0] thermal_result,        // last conversion result
    output reg [4:0] state_out,             // one-hot supply state
    output wire [1:0] wave_source,          // selected waveform source
    output wire [2:0] wave_index            // selected flash waveform
);

// ==========================================================
// one-hot states
localparam [4:0] ST_STANDBY = 5'h01;
localparam [4:0] ST_WARMUP = 5'h02;
localparam [4:0] ST_STABLE = 5'h04;
localparam [4:0] ST_UPDATE = 5'h08;
localparam [4:0] ST_SHUTDOWN = 5'h10;
localparam [22:0] SHUTDOWN_LAST = `EPU_SHUTDOWN_STEPS - 1;

reg [4:0] state_reg;
reg [4:0] state_next;
reg [22:0] cnt_reg;
reg [22:0] cnt_next;
reg [22:0] thr_cnt_reg;
reg [2:0] pend_reg;
reg next_backplane_bit_reg;
reg [1:0] colour_mode_reg;
reg [2:0] waveform_choice_reg;
reg chain_prev_reg;
reg bp_next;
reg rails_on;

wire [9:0] pins_s;
wire slave_s;
wire trig_s;
wire chain_s;
wire [6:0] adc_s;
wire chain_rise;
wire cmd_ok;
wire at_standby;
wire at_stable;
wire in_update;
wire take_power_on;
wire take_power_down;
wire take_update;
wire take_trigger;
wire take_thermal;
wire take_mode_cmd;

// ==========================================================
// pin synchronisers
epu_sync2 #(
    .WIDTH(10)
) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .din({thermal_adc_value, chain_clock_pin, update_trigger_pin, secondary_select_pin}),
    .dout(pins_s)
);

assign slave_s = pins_s[0];
assign trig_s = pins_s[1];
assign chain_s = pins_s[2];
assign adc_s = pins_s[9:3];

// ==========================================================
// chain clock rising edge from the synchronised copy
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        chain_prev_reg <= 1'b0;
    end else begin
        chain_prev_reg <= chain_s;
    end
end

assign chain_rise = chain_s & ~chain_prev_reg;

// ==========================================================
// command acceptance, nothing taken while converting
assign at_standby = state_reg[0];
assign at_stable = state_reg[2];
assign in_update = state_reg[3];
assign cmd_ok = cmd_strobe & ~thermal_busy;
assign take_power_on = cmd_ok & at_standby & (cmd_code == `EPU_CMD_POWER_ON);
assign take_power_down = cmd_ok & at_stable & (cmd_code == `EPU_CMD_POWER_DOWN);
assign take_update = cmd_ok & at_stable & ~slave_s
    & (cmd_code == `EPU_CMD_UPDATE_START);
assign take_trigger = at_stable & slave_s & ~thermal_busy & chain_rise & trig_s;
assign take_thermal = cmd_ok & (at_standby | at_stable)
    & (cmd_code == `EPU_CMD_THERMAL);
assign take_mode_cmd = cmd_ok & ~in_update;

// ==========================================================
// state and shared counter next values
always @* begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
        ST_STANDBY: begin
            if (take_power_on) begin
                state_next = ST_WARMUP;
                cnt_next = 23'h000000;
            end
        end
        ST_WARMUP: begin
            if (cnt_reg == WARMUP_CYCLES - 23'h000001) begin
                state_next = ST_STABLE;
            end else begin
                cnt_next = cnt_reg + 23'h000001;
            end
        end
        ST_STABLE: begin
            if (take_power_down) begin
                state_next = ST_SHUTDOWN;
                cnt_next = 23'h000000;
            end else if (take_update || take_trigger) begin
                state_next = ST_UPDATE;
                cnt_next = 23'h000000;
            end
        end
        ST_UPDATE: begin
            if (cnt_reg == UPDATE_CYCLES - 23'h000001) begin
                state_next = ST_STABLE;
            end else begin
                cnt_next = cnt_reg + 23'h000001;
            end
        end
        ST_SHUTDOWN: begin
            if (cnt_reg == SHUTDOWN_LAST) begin
                state_next = ST_STANDBY;
            end else begin
                cnt_next = cnt_reg + 23'h000001;
            end
        end
        default: begin
            state_next = ST_STANDBY;
            cnt_next = 23'h000000;
        end
    endcase
end

// ==========================================================
// supplies on from warm-up until shutdown begins
always @* begin
    rails_on = state_next[1] | state_next[2] | state_next[3];
end

// ==========================================================
// backplane drive from colour mode, stored bit rewritten only by its parameter byte
always @* begin
    case (colour_mode_reg)
        `EPU_MODE_NORMAL: bp_next = next_backplane_bit_reg;
        `EPU_MODE_REVERSE: bp_next = ~next_backplane_bit_reg;
        `EPU_MODE_WHITE: bp_next = 1'b0;
        `EPU_MODE_BLACK: bp_next = 1'b1;
        default: bp_next = 1'b0;
    endcase
end

// ==========================================================
// state, counter and supply outputs
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        state_reg <= ST_STANDBY;
        cnt_reg <= 23'h000000;
        state_out <= ST_STANDBY;
        first_boost_rail_en <= 1'b0;
        panel_drive_rail_en <= 1'b0;
        second_boost_rail_en <= 1'b0;
        high_voltage_regulator_en <= 1'b0;
        osc_en <= 1'b0;
        update_busy <= 1'b0;
        backplane_drive_black <= 1'b0;
    end else begin
        state_reg <= state_next;
        cnt_reg <= cnt_next;
        state_out <= state_next;
        // rails drop on the first shutdown cycle, oscillator one later
        first_boost_rail_en <= rails_on;
        panel_drive_rail_en <= rails_on & ~cap_booster_select;
        second_boost_rail_en <= rails_on & cap_booster_select;
        high_voltage_regulator_en <= rails_on & cap_booster_select;
        osc_en <= rails_on | (state_next[4] & (cnt_next != SHUTDOWN_LAST));
        update_busy <= state_next[3];
        backplane_drive_black <= state_next[3] & bp_next;
    end
end

// ==========================================================
// pending parameter command and stored mode fields
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        pend_reg <= 3'h0;
        next_backplane_bit_reg <= `EPU_NBP_RST;
        colour_mode_reg <= `EPU_MODE_RST;
        waveform_choice_reg <= `EPU_WAVE_RST;
    end else if (cmd_strobe) begin
        // a new command byte drops any unfinished parameter wait
        pend_reg[0] <= take_mode_cmd & (cmd_code == `EPU_CMD_BACKPLANE);
        pend_reg[1] <= take_mode_cmd & (cmd_code == `EPU_CMD_COLOUR);
        pend_reg[2] <= take_mode_cmd & (cmd_code == `EPU_CMD_WAVEFORM);
    end else if (param_strobe) begin
        pend_reg <= 3'h0;
        if (pend_reg[0] && !in_update) begin
            next_backplane_bit_reg <= param_byte[`EPU_NBP_BIT];
        end
        if (pend_reg[1] && !in_update) begin
            colour_mode_reg <= param_byte[`EPU_MODE_HI:`EPU_MODE_LO];
        end
        if (pend_reg[2] && !in_update
            && param_byte[`EPU_WAVE_HI:`EPU_WAVE_LO] != `EPU_WAVE_PROHIBITED) begin
            waveform_choice_reg <= param_byte[`EPU_WAVE_HI:`EPU_WAVE_LO];
        end
    end
end

// ==========================================================
// temperature conversion timer and result register
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        thermal_busy <= 1'b0;
        thr_cnt_reg <= 23'h000000;
        thermal_result <= 7'h00;
    end else if (take_thermal) begin
        thermal_busy <= 1'b1;
        thr_cnt_reg <= 23'h000000;
    end else if (thermal_busy) begin
        if (thr_cnt_reg == THERMAL_CYCLES - 23'h000001) begin
            thermal_busy <= 1'b0;
            thermal_result <= adc_s;
        end else begin
            thr_cnt_reg <= thr_cnt_reg + 23'h000001;
        end
    end
end

// ==========================================================
// waveform memory selection
epu_wave_pick u_pick (
    .mclk(mclk),
    .rst_b(rst_b),
    .nvm_bypass(nvm_bypass),
    .is_slave(slave_s),
    .auto_thermal_pick(auto_thermal_pick),
    .waveform_choice(waveform_choice_reg),
    .thermal_result(thermal_result),
    .thermal_bounds(thermal_bounds),
    .wave_source(wave_source),
    .wave_index(wave_index)
);

endmodule
`default_nettype wire

// ===== hw/epu_consts.vh
// constants for the panel driver power, update and mode command decoder
`ifndef EPU_CONSTS_VH
`define EPU_CONSTS_VH

// ==========================================================
// command codes
`define EPU_CMD_POWER_ON 8'h11
`define EPU_CMD_POWER_DOWN 8'h12
`define EPU_CMD_UPDATE_START 8'h13
`define EPU_CMD_BACKPLANE 8'h20
`define EPU_CMD_COLOUR 8'h21
`define EPU_CMD_WAVEFORM 8'h22
`define EPU_CMD_THERMAL 8'h23

// ==========================================================
// parameter byte field positions
`define EPU_NBP_BIT 0
`define EPU_MODE_HI 3
`define EPU_MODE_LO 2
`define EPU_WAVE_HI 2
`define EPU_WAVE_LO 0

// ==========================================================
// reset values and the prohibited waveform number
`define EPU_NBP_RST 1'h0
`define EPU_MODE_RST 2'h0
`define EPU_WAVE_RST 3'h1
`define EPU_WAVE_PROHIBITED 3'h0

// ==========================================================
// colour modes
`define EPU_MODE_NORMAL 2'h0
`define EPU_MODE_REVERSE 2'h1
`define EPU_MODE_WHITE 2'h2
`define EPU_MODE_BLACK 2'h3

// ==========================================================
// waveform sources
`define EPU_SRC_HOST_TABLE 2'h0
`define EPU_SRC_FLASH_CHOICE 2'h1
`define EPU_SRC_FLASH_THERMAL 2'h2

// ==========================================================
// timing
`define EPU_CLK_KHZ 25000
`define EPU_WARMUP_MS 200
`define EPU_THERMAL_US 3500
`define EPU_UPDATE_CYCLES 1000
`define EPU_SHUTDOWN_STEPS 2

`endif

// ===== hw/epu_sync2.v
// two flip-flop synchroniser for pins from outside the mclk domain
`timescale 1ns/10ps
`default_nettype none

module epu_sync2 #(
    parameter WIDTH = 1
) (
    input wire mclk,               // system clock
    input wire rst_b,              // async reset, active low
    input wire [WIDTH-1:0] din,    // asynchronous inputs
    output reg [WIDTH-1:0] dout    // synchronised copies
);

reg [WIDTH-1:0] meta_reg;

// ==========================================================
// first stage feeds only the second stage
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        meta_reg <= {WIDTH{1'b0}};
        dout <= {WIDTH{1'b0}};
    end else begin
        meta_reg <= din;
        dout <= meta_reg;
    end
end

endmodule
`default_nettype wire

// ===== hw/epu_wave_pick.v
// waveform memory selection from flash bypass, chip role and temperature
`timescale 1ns/10ps
`default_nettype none
`include "epu_consts.vh"

module epu_wave_pick (
    input wire mclk,                  // system clock
    input wire rst_b,                 // async reset, active low
    input wire nvm_bypass,            // 1: host waveform table in use
    input wire is_slave,              // synced secondary select pin
    input wire auto_thermal_pick,     // automatic temperature pick on
    input wire [2:0] waveform_choice, // stored selection 1..7
    input wire [6:0] thermal_result,  // last conversion result
    input wire [41:0] thermal_bounds, // six 7-bit boundaries, ascending
    output reg [1:0] wave_source,     // selected memory source
    output reg [2:0] wave_index       // selected flash waveform
);

wire [5:0] above;
reg [2:0] temp_index;
integer k;

// ==========================================================
// one comparator per temperature boundary
genvar g;
generate
    for (g = 0; g < 6; g = g + 1) begin : gen_bound
        assign above[g] = (thermal_result >= thermal_bounds[g*7+6:g*7]);
    end
endgenerate

// ==========================================================
// waveform number is one plus boundaries passed
always @* begin
    temp_index = 3'h1;
    for (k = 0; k < 6; k = k + 1) begin
        temp_index = temp_index + {2'h0, above[k]};
    end
end

// ==========================================================
// register the source and index
always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
        wave_source <= `EPU_SRC_FLASH_CHOICE;
        wave_index <= `EPU_WAVE_RST;
    end else if (nvm_bypass) begin
        wave_source <= `EPU_SRC_HOST_TABLE;
        wave_index <= waveform_choice;
    end else if (is_slave || !auto_thermal_pick) begin
        wave_source <= `EPU_SRC_FLASH_CHOICE;
        wave_index <= waveform_choice;
    end else begin
        wave_source <= `EPU_SRC_FLASH_THERMAL;
        wave_index <= temp_index;
    end
end

endmodule
`default_nettype wire

// ===== dv/epu_host_model.sv
// host controller model driving the command port and the chain pins
`timescale 1ns/10ps
`default_nettype none

module epu_host_model (
    input wire mclk,                 // system clock
    output logic cmd_strobe,         // command byte valid
    output logic [7:0] cmd_code,     // command byte
    output logic param_strobe,       // parameter byte valid
    output logic [7:0] param_byte,   // parameter byte
    output logic update_trigger_pin, // trigger to slave
    output logic chain_clock_pin     // chain clock, still between frames
);
    // idle port at time zero
    initial begin
        cmd_strobe = 1'b0;
        cmd_code = 8'h00;
        param_strobe = 1'b0;
        param_byte = 8'h00;
        update_trigger_pin = 1'b0;
        chain_clock_pin = 1'b0;
    end

    // one command byte, held for one whole cycle; stale byte inverted after
    task send_cmd(input logic [7:0] c);
        @(negedge mclk);
        cmd_code = c;
        cmd_strobe = 1'b1;
        @(negedge mclk);
        cmd_strobe = 1'b0;
        cmd_code = ~c;
    endtask

    // one parameter byte; zero for the waveform field only when told to
    task send_param(input logic [7:0] p);
        @(negedge mclk);
        param_byte = p;
        param_strobe = 1'b1;
        @(negedge mclk);
        param_strobe = 1'b0;
        param_byte = ~p;
    endtask

    // one chain clock period of 320 ns with the trigger high across its rise
    task chain_trigger;
        update_trigger_pin = 1'b1;
        #160;
        chain_clock_pin = 1'b1;
        #160;
        chain_clock_pin = 1'b0;
        update_trigger_pin = 1'b0;
    endtask
endmodule

`default_nettype wire

// ===== dv/epu_cmd_decoder_asserts.sv
// concurrent checks on the command decoder ports
`timescale 1ns/10ps
`default_nettype none

module epu_chk #(
    parameter [22:0] THERMAL_CYCLES = 10,
    parameter [22:0] UPDATE_CYCLES = 8
) (
    input wire mclk,                      // system clock
    input wire rst_b,                     // async reset, active low
    input wire cmd_strobe,                // command valid
    input wire [7:0] cmd_code,            // command byte
    input wire secondary_select_pin,      // slave pin
    input wire update_trigger_pin,        // trigger pin
    input wire nvm_bypass,                // host table select
    input wire first_boost_rail_en,       // first rail
    input wire panel_drive_rail_en,       // panel rail
    input wire second_boost_rail_en,      // second rail
    input wire high_voltage_regulator_en, // regulator
    input wire osc_en,                    // oscillator
    input wire update_busy,               // update running
    input wire backplane_drive_black,     // backplane drive
    input wire thermal_busy,              // conversion running
    input wire [6:0] thermal_result,      // conversion result
    input wire [4:0] state_out,           // one-hot state
    input wire [1:0] wave_source          // waveform source
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // ==========================================================
    // busy length counters
    reg [22:0] upd_cnt_reg;
    reg [22:0] thm_cnt_reg;
    wire cmd_ok;

    // count sampled busy cycles, cleared when idle
    always @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            upd_cnt_reg <= 23'h0;
            thm_cnt_reg <= 23'h0;
        end else begin
            upd_cnt_reg <= update_busy ? upd_cnt_reg + 23'h1 : 23'h0;
            thm_cnt_reg <= thermal_busy ? thm_cnt_reg + 23'h1 : 23'h0;
        end
    end

    // a command the decoder may act on
    assign cmd_ok = cmd_strobe && !thermal_busy;

    // ==========================================================
    // properties

    sequence s_rails_off;
        state_out == 5'h10 && !first_boost_rail_en && !panel_drive_rail_en &&
            !second_boost_rail_en && !high_voltage_regulator_en;
    endsequence
    sequence s_shutdown;
        s_rails_off ##1 !osc_en ##1 state_out == 5'h01;
    endsequence

    a_pwrdn_sequence: assert property (cmd_ok && cmd_code == 8'h12 && state_out == 5'h04
        |=> s_shutdown) else $error("power down sequence wrong");
    a_pwrdn_refused: assert property (cmd_ok && cmd_code == 8'h12 && state_out == 5'h01
        |=> state_out == 5'h01) else $error("power down taken in standby");
    a_master_start: assert property (cmd_ok && cmd_code == 8'h13 && state_out == 5'h04 &&
        !secondary_select_pin && !$past(secondary_select_pin, 2)
        |=> state_out == 5'h08 && update_busy) else $error("master update not started");
    a_slave_ignore: assert property (cmd_ok && cmd_code == 8'h13 && state_out == 5'h04 &&
        secondary_select_pin && $past(secondary_select_pin, 2) && !update_trigger_pin &&
        !$past(update_trigger_pin, 2) |=> state_out == 5'h04) else $error("slave took update");
    a_update_len: assert property ($fell(update_busy) |-> upd_cnt_reg == UPDATE_CYCLES)
        else $error("update length wrong");
    a_thermal_len: assert property ($fell(thermal_busy) |-> thm_cnt_reg == THERMAL_CYCLES)
        else $error("conversion length wrong");
    a_thermal_start: assert property (cmd_ok && cmd_code == 8'h23 &&
        (state_out == 5'h01 || state_out == 5'h04) |=> thermal_busy) else $error("no conversion");
    a_conv_quiet: assert property (thermal_busy && cmd_strobe && state_out == 5'h04
        |=> state_out == 5'h04) else $error("command acted on during conversion");
    a_drive_idle: assert property (!update_busy |-> !backplane_drive_black)
        else $error("backplane driven outside update");
    a_drive_steady: assert property (update_busy && $past(update_busy)
        |-> $stable(backplane_drive_black)) else $error("drive changed in update");
    a_result_hold: assert property (!thermal_busy && !$past(thermal_busy)
        |-> $stable(thermal_result)) else $error("result changed while idle");
    a_bypass_source: assert property (nvm_bypass && $past(nvm_bypass) && $past(rst_b)
        |-> wave_source == 2'h0) else $error("bypass not using host table");
endmodule

bind epu_cmd_decoder epu_chk #(.THERMAL_CYCLES(THERMAL_CYCLES), .UPDATE_CYCLES(UPDATE_CYCLES))
    u_epu_chk (.mclk(mclk), .rst_b(rst_b), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .secondary_select_pin(secondary_select_pin), .update_trigger_pin(update_trigger_pin),
    .nvm_bypass(nvm_bypass), .first_boost_rail_en(first_boost_rail_en),
    .panel_drive_rail_en(panel_drive_rail_en), .second_boost_rail_en(second_boost_rail_en),
    .high_voltage_regulator_en(high_voltage_regulator_en), .osc_en(osc_en),
    .update_busy(update_busy), .backplane_drive_black(backplane_drive_black),
    .thermal_busy(thermal_busy), .thermal_result(thermal_result), .state_out(state_out),
    .wave_source(wave_source));

`default_nettype wire

// ===== dv/epu_cmd_decoder_tb.sv
// self-checking bench for the command decoder
`timescale 1ns/10ps
`default_nettype none

module epu_cmd_decoder_tb;
    logic mclk;
    logic rst_b;
    logic cap_booster_select, nvm_bypass, auto_thermal_pick, secondary_select_pin;
    logic [6:0] thermal_adc_value;
    logic [41:0] thermal_bounds;
    wire cmd_strobe, param_strobe, update_trigger_pin, chain_clock_pin;
    wire [7:0] cmd_code, param_byte;
    wire first_boost_rail_en, panel_drive_rail_en, second_boost_rail_en;
    wire high_voltage_regulator_en, osc_en, update_busy, backplane_drive_black, thermal_busy;
    wire [6:0] thermal_result;
    wire [4:0] state_out;
    wire [1:0] wave_source;
    wire [2:0] wave_index;
    int err_count;
    int samples_checked;
    int cyc;
    // rows: colour mode, backplane bit, expected drive (1 black)
    logic [3:0] rows [8] = '{4'h0, 4'h3, 4'h5, 4'h6, 4'h8, 4'hA, 4'hD, 4'hF};

    // ==========================================================
    // design, host and clock
    epu_cmd_decoder #(.WARMUP_CYCLES(23'h14), .THERMAL_CYCLES(23'hA), .UPDATE_CYCLES(23'h8))
        u_epu_cmd_decoder (.mclk(mclk), .rst_b(rst_b), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code), .param_strobe(param_strobe), .param_byte(param_byte),
        .cap_booster_select(cap_booster_select), .nvm_bypass(nvm_bypass),
        .auto_thermal_pick(auto_thermal_pick), .secondary_select_pin(secondary_select_pin),
        .update_trigger_pin(update_trigger_pin), .chain_clock_pin(chain_clock_pin),
        .thermal_adc_value(thermal_adc_value), .thermal_bounds(thermal_bounds),
        .first_boost_rail_en(first_boost_rail_en), .panel_drive_rail_en(panel_drive_rail_en),
        .second_boost_rail_en(second_boost_rail_en),
        .high_voltage_regulator_en(high_voltage_regulator_en), .osc_en(osc_en),
        .update_busy(update_busy), .backplane_drive_black(backplane_drive_black),
        .thermal_busy(thermal_busy), .thermal_result(thermal_result), .state_out(state_out),
        .wave_source(wave_source), .wave_index(wave_index));
    epu_host_model u_epu_host_model (.mclk(mclk), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
        .param_strobe(param_strobe), .param_byte(param_byte),
        .update_trigger_pin(update_trigger_pin), .chain_clock_pin(chain_clock_pin));

    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            err_count++;
            end_of_test();
        end
    end

    // ==========================================================
    // helpers
    task chk(input logic [7:0] seen, input logic [7:0] exp, input string nm);
        samples_checked++;
        if (seen !== exp) begin
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
            err_count++;
        end
    endtask

    task wait_state(input logic [4:0] s);
        repeat (100) if (state_out !== s) @(negedge mclk);
        if (state_out !== s) err_count++;
    endtask

    task cmd(input logic [7:0] c);
        u_epu_host_model.send_cmd(c);
    endtask

    task cmd_p(input logic [7:0] c, input logic [7:0] p);
        u_epu_host_model.send_cmd(c);
        u_epu_host_model.send_param(p);
    endtask

    // power on, then wait out the warm-up before anything else
    task power_on;
        cmd(8'h11);
        wait_state(5'h04);
    endtask

    task end_of_test;
        if (err_count == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        {cap_booster_select, nvm_bypass, auto_thermal_pick, secondary_select_pin} = 4'h0;
        thermal_adc_value = 7'h25;
        thermal_bounds = {7'h3C, 7'h32, 7'h28, 7'h1E, 7'h14, 7'h0A};
        err_count = 0;
        samples_checked = 0;
        rst_b = 1'b0;
        repeat (2) @(negedge mclk);
        rst_b = 1'b1;
        chk(state_out, 8'h01, "state");
        chk(wave_index, 8'h01, "wave_index");
        chk(wave_source, 8'h01, "wave_source");
        cmd(8'h12);
        repeat (2) @(negedge mclk);
        chk(state_out, 8'h01, "state");
        power_on();
        chk({first_boost_rail_en, panel_drive_rail_en, second_boost_rail_en}, 8'h06,
            "rails");
        cmd(8'h13);
        @(negedge mclk);
        chk(update_busy, 8'h01, "busy");
        chk(backplane_drive_black, 8'h00, "drive");
        wait_state(5'h04);
        // colour mode table
        for (int i = 0; i < 8; i++) begin
            cmd_p(8'h20, {7'h00, rows[i][1]});
            cmd_p(8'h21, {4'h0, rows[i][3:2], 2'h0});
            cmd(8'h13);
            @(negedge mclk);
            chk(backplane_drive_black, {7'h00, rows[i][0]}, "drive");
            wait_state(5'h04);
            chk(backplane_drive_black, 8'h00, "drive idle");
        end
        // mode write during update dropped
        cmd(8'h13);
        cmd_p(8'h21, 8'h00);
        wait_state(5'h04);
        cmd(8'h13);
        @(negedge mclk);
        chk(backplane_drive_black, 8'h01, "drive");
        wait_state(5'h04);
        // waveform field, prohibited zero kept out
        cmd_p(8'h22, 8'h05);
        repeat (2) @(negedge mclk);
        chk(wave_index, 8'h05, "wave_index");
        cmd_p(8'h22, 8'h00);
        repeat (2) @(negedge mclk);
        chk(wave_index, 8'h05, "wave_index");
        // conversion, power down refused
        cmd(8'h23);
        @(negedge mclk);
        chk(thermal_busy, 8'h01, "thermal_busy");
        cmd(8'h12);
        repeat (20) if (thermal_busy) @(negedge mclk);
        chk(state_out, 8'h04, "state");
        chk(thermal_result, 8'h25, "result");
        auto_thermal_pick = 1'b1;
        repeat (2) @(negedge mclk);
        chk({wave_source, wave_index}, 8'h14, "pick");
        secondary_select_pin = 1'b1;
        repeat (4) @(negedge mclk);
        chk({wave_source, wave_index}, 8'h0D, "pick");
        nvm_bypass = 1'b1;
        repeat (2) @(negedge mclk);
        chk(wave_source, 8'h00, "source");
        nvm_bypass = 1'b0;
        // slave: command ignored, trigger at chain clock rise starts it
        cmd(8'h13);
        repeat (2) @(negedge mclk);
        chk(state_out, 8'h04, "state");
        u_epu_host_model.chain_trigger();
        repeat (20) if (!update_busy) @(negedge mclk);
        chk(update_busy, 8'h01, "busy");
        wait_state(5'h04);
        cmd(8'h12);
        wait_state(5'h01);
        chk({first_boost_rail_en, panel_drive_rail_en, osc_en}, 8'h00, "off");
        cmd(8'h23);
        @(negedge mclk);
        chk(thermal_busy, 8'h01, "thermal_busy");
        repeat (20) if (thermal_busy) @(negedge mclk);
        // capacitor booster supplies
        cap_booster_select = 1'b1;
        power_on();
        chk({second_boost_rail_en, high_voltage_regulator_en, panel_drive_rail_en}, 8'h06,
            "cap rails");
        cmd(8'h12);
        wait_state(5'h01);
        chk({second_boost_rail_en, high_voltage_regulator_en, osc_en}, 8'h00, "off");
        power_on();
        rst_b = 1'b0;
        @(negedge mclk);
        rst_b = 1'b1;
        chk(state_out, 8'h01, "state");
        end_of_test();
    end
endmodule

`default_nettype wire
